// ### core/pwd_params.svh
// Functional notes
// RQ1: Time-out after 16K cycles for select code 000, doubling per code up to 2048K.
// RQ2: Counter is a 14-bit timer clocked through a 7-bit prescaler.
// RQ3: Watchdog is off after any reset and while in power-down.
// RQ4: Expiry without a valid feed emits an internal CPU reset pulse.
// RQ5: Writing 1EH then E1H to the feed register starts counting.
// RQ6: Control bit 0 is a read-only flag showing the watchdog runs.
// RQ7: Software repeats the key pair before expiry to avoid a reset.
// RQ8: Reads may fall between the two key writes; any other write breaks it.
// RQ9: A wrong key sequence triggers an immediate watchdog reset.
// RQ10: Control bit 4 set freezes the counter while the device idles.
// RQ11: Overflow flag bit 1 is set by expiry or bad keys; software clears it.
// RQ12: Control holds period select 7:5, freeze 4, overflow 1, running 0.
// RQ13: Feed register sits at address A6H and is not bit addressable.
// RQ14: Overflow flag survives the reset that the watchdog itself causes.
// RQ15: A valid feed clears both the prescaler and the timer.
`ifndef PWD_PARAMS_SVH
`define PWD_PARAMS_SVH

`define PWD_ADDR_FEED   8'ha6
`define PWD_ADDR_CTRL   8'ha7
`define PWD_ADDR_ISTAT  8'ha8
`define PWD_ADDR_IMASK  8'ha9

`define PWD_KEY_FIRST   8'h1e
`define PWD_KEY_SECOND  8'he1

`define PWD_CTRL_PS_HI  7
`define PWD_CTRL_PS_LO  5
`define PWD_CTRL_FRZ    4
`define PWD_CTRL_OVF    1
`define PWD_CTRL_RUN    0

`define PWD_IRQ_TMO     0
`define PWD_IRQ_BAD     1
`define PWD_IRQ_W       2

`define PWD_PRESC_W     7
`define PWD_TIMER_W     14
`define PWD_RST_PS      3'h0
`define PWD_RST_IRQ     2'h0
`define PWD_RST_BYTE    8'h00

`endif

// ### core/pwd_pkg.sv
package pwd_pkg;

  typedef enum logic [1:0] {
    PWD_SEQ_IDLE  = 2'b01,
    PWD_SEQ_ARMED = 2'b10
  } pwd_seq_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pwd_bus_req_t;

endpackage : pwd_pkg

// ### core/pwd_watchdog.sv
`timescale 1ns/1ps
`include "pwd_params.svh"

module pwd_watchdog
  import pwd_pkg::*;
#(
  parameter int PRESC_W = `PWD_PRESC_W,
  parameter int TIMER_W = `PWD_TIMER_W
) (
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire pwd_bus_req_t bus_req,
  output logic [7:0]        bus_rdata,
  input  wire logic         idle_mode,
  input  wire logic         power_down,
  output logic              cpu_reset_pulse,
  output logic              irq
);

  typedef struct packed {
    pwd_seq_t                seq;
    logic                    run;
    logic [2:0]              ps;
    logic                    frz;
    logic                    ovf;
    logic [PRESC_W-1:0]      presc;
    logic [TIMER_W-1:0]      timer;
    logic                    rst_pulse;
    logic [`PWD_IRQ_W-1:0]   istat;
    logic [`PWD_IRQ_W-1:0]   imask;
    logic [7:0]              rdata;
  } pwd_state_t;

  pwd_state_t st_r;
  pwd_state_t st_nxt;

  // Timer advances when the low sel bits of the prescaler are all ones
  function automatic logic presc_tick(
    input logic [PRESC_W-1:0] presc,
    input logic [2:0]         sel
  );
    logic [PRESC_W-1:0] mask;
    mask = PRESC_W'((1 << sel) - 1);
    return (presc & mask) == mask;
  endfunction : presc_tick

  function automatic logic addr_hit(
    input pwd_bus_req_t req,
    input logic [7:0]   addr
  );
    return req.addr == addr;
  endfunction : addr_hit

  // Interrupt fields are narrower than the bus; upper bits read as zero
  function automatic logic [7:0] irq_byte(
    input logic [`PWD_IRQ_W-1:0] bits
  );
    return {{(8-`PWD_IRQ_W){1'b0}}, bits};
  endfunction : irq_byte

  logic       feed_wr;
  logic       ctrl_wr;
  logic       istat_wr;
  logic       imask_wr;
  logic       other_wr;
  logic       key_ok;
  logic       key_bad;
  logic       hold;
  logic       count_en;
  logic       tick;
  logic       expire;
  logic       bite;
  logic [7:0] ctrl_rd;

  always_comb begin
    feed_wr  = bus_req.wr && addr_hit(bus_req, `PWD_ADDR_FEED); // RQ13
    ctrl_wr  = bus_req.wr && addr_hit(bus_req, `PWD_ADDR_CTRL);
    istat_wr = bus_req.wr && addr_hit(bus_req, `PWD_ADDR_ISTAT);
    imask_wr = bus_req.wr && addr_hit(bus_req, `PWD_ADDR_IMASK);
    other_wr = bus_req.wr && !feed_wr;
  end

  // Key sequence checker
  always_comb begin
    key_ok  = 1'b0;
    key_bad = 1'b0;
    unique case (st_r.seq)
      PWD_SEQ_IDLE: begin
        if (feed_wr && bus_req.wdata != `PWD_KEY_FIRST) begin
          key_bad = 1'b1; // RQ9
        end
      end
      PWD_SEQ_ARMED: begin
        if (feed_wr) begin
          if (bus_req.wdata == `PWD_KEY_SECOND) begin
            key_ok = 1'b1; // RQ5
          end else begin
            key_bad = 1'b1; // RQ9
          end
        end else if (other_wr) begin
          key_bad = 1'b1; // RQ8
        end
      end
      default: begin
        key_bad = 1'b0;
      end
    endcase
  end

  always_comb begin
    hold     = idle_mode && st_r.frz; // RQ10
    count_en = st_r.run && !hold && !power_down; // RQ3
    tick     = presc_tick(st_r.presc, st_r.ps); // RQ1
    expire   = count_en && tick && (&st_r.timer); // RQ4
    bite     = expire || key_bad;
  end

  always_comb begin
    ctrl_rd = `PWD_RST_BYTE;
    ctrl_rd[`PWD_CTRL_PS_HI:`PWD_CTRL_PS_LO] = st_r.ps; // RQ12
    ctrl_rd[`PWD_CTRL_FRZ] = st_r.frz;
    ctrl_rd[`PWD_CTRL_OVF] = st_r.ovf;
    ctrl_rd[`PWD_CTRL_RUN] = st_r.run; // RQ6
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.rst_pulse = bite; // RQ4

    // Key sequence state
    unique case (st_r.seq)
      PWD_SEQ_IDLE: begin
        if (feed_wr && bus_req.wdata == `PWD_KEY_FIRST) begin
          st_nxt.seq = PWD_SEQ_ARMED;
        end
      end
      PWD_SEQ_ARMED: begin
        if (bus_req.wr) begin
          st_nxt.seq = PWD_SEQ_IDLE; // RQ8
        end
      end
      // An illegal code falls back to waiting for the first key
      default: begin
        st_nxt.seq = PWD_SEQ_IDLE;
      end
    endcase

    // Counting chain
    if (count_en) begin
      st_nxt.presc = st_r.presc + PRESC_W'(1); // RQ2
      if (tick) begin
        st_nxt.timer = st_r.timer + TIMER_W'(1); // RQ2
      end
    end

    if (key_ok) begin
      st_nxt.run   = 1'b1; // RQ5
      st_nxt.presc = '0; // RQ15
      st_nxt.timer = '0; // RQ15
    end

    // Watchdog reset disables the counter
    if (bite) begin
      st_nxt.run   = 1'b0; // RQ3
      st_nxt.seq   = PWD_SEQ_IDLE;
      st_nxt.presc = '0;
      st_nxt.timer = '0;
    end

    if (power_down) begin
      st_nxt.run   = 1'b0; // RQ3
      st_nxt.presc = '0;
      st_nxt.timer = '0;
    end

    // Control register fields
    if (ctrl_wr) begin
      st_nxt.ps  = bus_req.wdata[`PWD_CTRL_PS_HI:`PWD_CTRL_PS_LO];
      st_nxt.frz = bus_req.wdata[`PWD_CTRL_FRZ];
      if (!bus_req.wdata[`PWD_CTRL_OVF]) begin
        st_nxt.ovf = 1'b0; // RQ11
      end
    end
    if (bite) begin
      st_nxt.ovf = 1'b1; // RQ11 RQ14
    end

    // Interrupt mask and sticky status
    if (imask_wr) begin
      st_nxt.imask = bus_req.wdata[`PWD_IRQ_W-1:0];
    end
    if (istat_wr) begin
      st_nxt.istat = st_r.istat & ~bus_req.wdata[`PWD_IRQ_W-1:0];
    end
    // Set wins over a clear in the same cycle
    if (expire) begin
      st_nxt.istat[`PWD_IRQ_TMO] = 1'b1;
    end
    if (key_bad) begin
      st_nxt.istat[`PWD_IRQ_BAD] = 1'b1;
    end

    // Read data stands for one cycle after the strobe, zero otherwise
    st_nxt.rdata = `PWD_RST_BYTE;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `PWD_ADDR_CTRL: begin
          st_nxt.rdata = ctrl_rd; // RQ6
        end
        `PWD_ADDR_ISTAT: begin
          st_nxt.rdata = irq_byte(st_r.istat);
        end
        `PWD_ADDR_IMASK: begin
          st_nxt.rdata = irq_byte(st_r.imask);
        end
        // Feed register is write-only; it and unmapped addresses read zero
        default: begin
          st_nxt.rdata = `PWD_RST_BYTE; // RQ13
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r.seq       <= PWD_SEQ_IDLE;
      st_r.run       <= 1'b0; // RQ3
      st_r.ps        <= `PWD_RST_PS; // RQ12
      st_r.frz       <= 1'b0;
      st_r.ovf       <= 1'b0;
      st_r.presc     <= '0;
      st_r.timer     <= '0;
      st_r.rst_pulse <= 1'b0;
      st_r.istat     <= `PWD_RST_IRQ;
      st_r.imask     <= `PWD_RST_IRQ;
      st_r.rdata     <= `PWD_RST_BYTE;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    bus_rdata       = st_r.rdata;
    cpu_reset_pulse = st_r.rst_pulse;
    irq             = |(st_r.istat & st_r.imask);
  end

endmodule : pwd_watchdog

// ### test/pwd_watchdog_monitor.sv
`timescale 1ns/1ps
module pwd_watchdog_monitor
  import pwd_pkg::*;
(
  input wire logic         clk_sys,
  input wire logic         reset_n,
  input wire pwd_bus_req_t bus_req,
  input wire logic [7:0]   bus_rdata,
  input wire logic         idle_mode,
  input wire logic         power_down,
  input wire logic         cpu_reset_pulse,
  input wire logic         irq
);
  logic wf;
  logic rc;
  assign wf = bus_req.wr && bus_req.addr == 8'ha6;
  assign rc = bus_req.rd && bus_req.addr == 8'ha7;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_pulse_one: assert property (cpu_reset_pulse |=> !cpu_reset_pulse)
    else $error("pulse too long");
  a_bad_key: assert property (
    wf && !(bus_req.wdata inside {8'h1e, 8'he1}) |=> cpu_reset_pulse) else $error("no bite");
  a_feed_read: assert property (
    bus_req.rd && bus_req.addr == 8'ha6 |=> bus_rdata == 8'h00) else $error("feed read");
  a_ctrl_gap: assert property (rc |=> bus_rdata[3:2] == 2'h0)
    else $error("unused bits");
  a_run_pd: assert property ($past(power_down) && power_down && rc |=> !bus_rdata[0])
    else $error("runs in power-down");
  a_bite_flags: assert property (
    rc && cpu_reset_pulse |=> bus_rdata[1:0] == 2'b10) else $error("flags after bite");
  a_key_run: assert property (
    (wf && bus_req.wdata == 8'h1e) ##1
    (wf && bus_req.wdata == 8'he1 && !cpu_reset_pulse && !power_down) ##1
    (rc && !power_down && !cpu_reset_pulse) |=> bus_rdata[0]) else $error("not running");
  a_key_break: assert property (
    (wf && bus_req.wdata == 8'h1e) ##1 (bus_req.wr && bus_req.addr != 8'ha6 && !cpu_reset_pulse)
    |=> cpu_reset_pulse) else $error("break not caught");
endmodule : pwd_watchdog_monitor

bind pwd_watchdog pwd_watchdog_monitor pwd_watchdog_monitor_inst (
  .clk_sys(clk_sys), .reset_n(reset_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .idle_mode(idle_mode), .power_down(power_down), .cpu_reset_pulse(cpu_reset_pulse), .irq(irq));

// ### test/tb.sv
`timescale 1ns/1ps
module tb
  import pwd_pkg::*;
;
  logic         clk_sys, reset_n, idle_mode, power_down, cpu_reset_pulse, irq;
  pwd_bus_req_t bus_req;
  logic [7:0]   bus_rdata;
  int           errors, compares, bites, n;

  pwd_watchdog pwd_watchdog_inst (.clk_sys(clk_sys), .reset_n(reset_n), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .idle_mode(idle_mode), .power_down(power_down),
    .cpu_reset_pulse(cpu_reset_pulse), .irq(irq));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (cpu_reset_pulse === 1'b1) bites <= bites + 1;

  task automatic chk(string s, logic [31:0] e, logic [31:0] v);
    compares++;
    if (e !== v) begin
      errors++;
      $display("Error %s expected %h seen %h", s, e, v);
    end
  endtask : chk
  // Requests stay up until the next task replaces them; rel drops them
  task automatic wr(logic [7:0] a, logic [7:0] d);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] m, logic [7:0] e);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
    #1 chk("rdata", e, bus_rdata & m);
  endtask : rd
  task automatic rel(int k);
    bus_req <= '0;
    repeat (k) @(posedge clk_sys);
  endtask : rel
  task automatic summarize();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic t_reset();
    rd(8'ha7, 8'hff, 8'h00);
    rd(8'ha6, 8'hff, 8'h00);
    rd(8'hb0, 8'hff, 8'h00);
    rd(8'ha8, 8'hff, 8'h00);
    rd(8'ha9, 8'hff, 8'h00);
    rel(1);
  endtask : t_reset
  task automatic t_enable();
    wr(8'ha6, 8'h1e);
    wr(8'ha6, 8'he1);
    rd(8'ha7, 8'h01, 8'h01);
    wr(8'ha7, 8'h00);
    rd(8'ha7, 8'h01, 8'h01);
    rel(10000);
  endtask : t_enable
  task automatic t_timeout();
    wr(8'ha6, 8'h1e);
    rd(8'ha7, 8'h01, 8'h01);
    wr(8'ha6, 8'he1);
    rel(1);
    chk("bites", 0, bites);
    n = 1;
    while (n < 20000 && cpu_reset_pulse !== 1'b1) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk("period", 16384, n);
    rd(8'ha7, 8'h03, 8'h02);
    rd(8'ha8, 8'hff, 8'h01);
    chk("irq", 0, irq);
    wr(8'ha9, 8'h01);
    rel(1);
    chk("irq", 1, irq);
    wr(8'ha8, 8'h01);
    rel(1);
    chk("irq", 0, irq);
    wr(8'ha7, 8'h00);
    rd(8'ha7, 8'h03, 8'h00);
    rel(1);
  endtask : t_timeout
  task automatic t_bad();
    wr(8'ha6, 8'h55);
    rd(8'ha7, 8'h03, 8'h02);
    rd(8'ha8, 8'h02, 8'h02);
    wr(8'ha6, 8'h1e);
    wr(8'ha7, 8'h00);
    rel(3);
    chk("bites", 3, bites);
    rd(8'ha7, 8'h02, 8'h02);
  endtask : t_bad
  task automatic t_idle();
    wr(8'ha7, 8'hff);
    rd(8'ha7, 8'hfc, 8'hf0);
    wr(8'ha7, 8'h10);
    wr(8'ha6, 8'h1e);
    wr(8'ha6, 8'he1);
    idle_mode <= 1'b1;
    rel(17000);
    chk("bites", 3, bites);
    power_down <= 1'b1;
    @(posedge clk_sys);
    @(posedge clk_sys);
    rd(8'ha7, 8'h01, 8'h00);
    power_down <= 1'b0;
    idle_mode <= 1'b0;
    rel(17000);
    chk("bites", 3, bites);
  endtask : t_idle
  task automatic t_rerst();
    wr(8'ha6, 8'h1e);
    wr(8'ha6, 8'he1);
    rel(1);
    reset_n <= 1'b0;
    rel(2);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    rd(8'ha7, 8'hff, 8'h00);
    idle_mode <= 1'b1;
    wr(8'ha6, 8'h1e);
    wr(8'ha6, 8'he1);
    rel(17000);
    idle_mode <= 1'b0;
    chk("bites", 4, bites);
    rd(8'ha7, 8'h03, 8'h02);
  endtask : t_rerst

  initial begin
    #400000;
    errors++;
    summarize();
  end
  initial begin
    reset_n = 1'b0;
    idle_mode = 1'b0;
    power_down = 1'b0;
    bus_req = '0;
    errors = 0;
    compares = 0;
    bites = 0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_enable();
    t_timeout();
    t_bad();
    t_idle();
    t_rerst();
    summarize();
  end
endmodule : tb
